// ===== hdl/csr_readout.sv
/*
 * Serial readout and command logic of a capacitive area sensor.
 * Assumes an SPI master in mode 0 on spi_sck_i, an analog front end
 * answering pix_data_i for the addressed pixel on clk_sys_i.
 */
// Function
// - SPI slave, clock phase zero and polarity zero; host drives clock, select.
// - Pixel delivery rate stays at or below four million per second.
// - Array is 152 columns by 200 rows; whole or part may be scanned.
// - Eight adjacent pixels per sense step, default from row zero column zero.
// - Window steps horizontally shift-count times, then once vertically, until done.
// - Scan starts at the loadable horizontal and vertical start positions.
// - Each row is read row-repeat times before moving down; a row repeat of zero reads it once.
// - Pixel total is 8 times (xshift+1) times (yshift+1) times row repeat, with a zero repeat counting as one.
// - Codes 0x11 start sensing, 0x20 read data, 0x21 read status.
// - Code 0x50 copies the control registers except the start positions into the FIFO.
// - Codes 0x75, 0x76, 0x77 write drive, sensitivity, self-test.
// - Codes 0x82, 0x83, 0x84 write xshift, yshift, row repeat.
// - Code 0x7C writes threshold; 0x7F, 0x81 load start positions.
// - Any code except data or status read resets FIFO pointers.
// - Start plus dummy byte returns nothing; first byte after about 363 cycles.
// - Afterwards one byte enters the FIFO every eight cycles.
// - Data available when fill level reaches the threshold.
// - Full FIFO stalls sensing without loss, resuming after reads.
// - After read and dummy byte, bytes flow while select and input low.
// - Select raised between bytes keeps unread bytes.
// - Select raised mid byte keeps that byte unread; host reissues the read.
// - Serial byte framing and output shifter reset while select is high.
// - Status bit zero shows data available.
`timescale 1ns/1ns
`default_nettype none
`include "csr_map.svh"

module csr_readout #(
    parameter int FIFO_AW = 5,
    parameter int LAT_CYC = `CSR_LAT_CYC
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic spi_sck_i,
    input wire logic spi_cs_n_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    input wire logic [7:0] pix_data_i,
    output logic [7:0] pix_col_o,
    output logic [7:0] pix_row_o,
    output logic pix_strobe_o,
    output logic [7:0] finger_drive_out_o,
    output logic [1:0] adc_sens_o,
    output logic [7:0] selftest_mode_o,
    output logic sensing_o,
    output logic stall_o,
    output logic data_available_flag_o
);
    localparam int DEPTH = 1 << FIFO_AW;
    localparam int MIN_PER = (`CSR_CLK_MHZ + `CSR_MAX_MPIX - 1) / `CSR_MAX_MPIX;
    localparam int PIX_PER = (`CSR_PIX_PERIOD > MIN_PER) ? `CSR_PIX_PERIOD : MIN_PER;
    localparam logic [8:0] PER_LOAD = 9'(PIX_PER - 1);
    localparam logic [8:0] LAT_LOAD = 9'(LAT_CYC - 1);
    localparam logic [FIFO_AW:0] FULL_LVL = (FIFO_AW + 1)'(DEPTH);
    localparam logic [3:0] DUMP_LAST = 4'(`CSR_DUMP_LEN - 1);

    function automatic logic [FIFO_AW:0] b2g(input logic [FIFO_AW:0] b);
        b2g = b ^ (b >> 1);
    endfunction : b2g

    function automatic logic [FIFO_AW:0] g2b(input logic [FIFO_AW:0] g);
        logic [FIFO_AW:0] b;
        b = g;
        for (int i = FIFO_AW - 1; i >= 0; i--)
        begin
            b[i] = b[i + 1] ^ g[i];
        end
        g2b = b;
    endfunction : g2b

    function automatic logic is_rd(input logic [7:0] op);
        is_rd = (op == `CSR_OP_RD_DATA) || (op == `CSR_OP_RD_STAT);
    endfunction : is_rd

    // FIFO storage, written on clk_sys_i, read on spi_sck_i
    logic [7:0] mem [0:DEPTH-1];

    // Link domain state
    logic [2:0] bit_q;
    logic [6:0] sh_q;
    logic [1:0] idx_q;
    logic [7:0] cmd_q;
    logic [7:0] prm_q;
    logic tgl_q;
    logic [FIFO_AW:0] rptr_q;
    logic [FIFO_AW:0] rgray_q;
    logic ufl_q;
    logic [7:0] nxt_q;
    logic [7:0] tx_q;
    logic [FIFO_AW:0] wg_s1_q;
    logic [FIFO_AW:0] wg_s2_q;
    logic da_s1_q;
    logic da_s2_q;
    logic stl_s1_q;
    logic stl_s2_q;

    // System domain state
    logic tg_s1_q;
    logic tg_s2_q;
    logic tg_s3_q;
    logic [FIFO_AW:0] rg_s1_q;
    logic [FIFO_AW:0] rg_s2_q;
    logic uf_s1_q;
    logic uf_s2_q;
    logic [FIFO_AW:0] wptr_q;
    logic [FIFO_AW:0] wgray_q;
    csr_pkg::csr_state_e st_q;
    logic [8:0] cnt_q;
    logic [2:0] pix_q;
    logic [7:0] xcnt_q;
    logic [7:0] ycnt_q;
    logic [7:0] rcnt_q;
    logic [7:0] col_q;
    logic [7:0] row_q;
    logic [3:0] didx_q;
    logic stall_q;
    logic da_q;
    logic strobe_q;
    logic [7:0] drive_q;
    logic [1:0] adc_q;
    logic [7:0] test_q;
    logic [7:0] thr_q;
    logic [7:0] xpos_q;
    logic [7:0] ypos_q;
    logic [7:0] xsh_q;
    logic [7:0] ysh_q;
    logic [7:0] rep_q;

    // Link domain decode
    wire spi_rstn = resetn_i & ~spi_cs_n_i;
    wire byte_done = (bit_q == `CSR_BIT_LAST);
    wire [7:0] rx = {sh_q, serial_data_in_i};
    wire in_data = (idx_q == 2'h2);
    wire new_instr = byte_done & ((idx_q == 2'h0) | (in_data & (rx != 8'h00)));
    wire param_done = byte_done & (idx_q == 2'h1);
    wire data_done = byte_done & in_data & ~new_instr;
    wire [FIFO_AW:0] wbin_spi = g2b(wg_s2_q);
    wire [FIFO_AW:0] rptr_inc = rptr_q + (FIFO_AW + 1)'(1'h1);
    wire [FIFO_AW:0] rd_at = data_done ? rptr_inc : rptr_q;
    wire rd_empty = (rd_at == wbin_spi);
    wire [7:0] spi_stat = {5'h00, ufl_q, stl_s2_q, da_s2_q};

    // Link domain: byte framing, cleared while select is high
    always_ff @(posedge spi_sck_i or negedge spi_rstn)
    begin
        if (!spi_rstn)
        begin
            bit_q <= 3'h0;
            sh_q <= 7'h00;
            idx_q <= 2'h0;
        end
        else
        begin
            bit_q <= bit_q + 3'h1;
            sh_q <= rx[6:0];
            if (new_instr)
                idx_q <= 2'h1;
            else if (param_done)
                idx_q <= 2'h2;
        end
    end

    // Link domain: command, read pointer and prefetch survive select
    always_ff @(posedge spi_sck_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cmd_q <= 8'h00;
            prm_q <= 8'h00;
            tgl_q <= 1'h0;
            rptr_q <= '0;
            ufl_q <= 1'h0;
            nxt_q <= 8'h00;
        end
        else if (new_instr)
        begin
            cmd_q <= rx;
            if (!is_rd(rx))
            begin
                rptr_q <= '0;
                ufl_q <= 1'h0;
            end
        end
        else if (param_done)
        begin
            prm_q <= rx;
            if (!is_rd(cmd_q))
                tgl_q <= ~tgl_q;
            if (cmd_q == `CSR_OP_RD_DATA)
            begin
                nxt_q <= mem[rd_at[FIFO_AW-1:0]];
                ufl_q <= ufl_q | rd_empty;
            end
            else if (cmd_q == `CSR_OP_RD_STAT)
                nxt_q <= spi_stat;
        end
        else if (data_done)
        begin
            if (cmd_q == `CSR_OP_RD_DATA)
            begin
                rptr_q <= rptr_inc;
                nxt_q <= mem[rd_at[FIFO_AW-1:0]];
                ufl_q <= ufl_q | rd_empty;
            end
            else
                nxt_q <= 8'h00;
        end
    end

    // Link domain synchronisers and read pointer in gray
    always_ff @(posedge spi_sck_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rgray_q <= '0;
            wg_s1_q <= '0;
            wg_s2_q <= '0;
            da_s1_q <= 1'h0;
            da_s2_q <= 1'h0;
            stl_s1_q <= 1'h0;
            stl_s2_q <= 1'h0;
        end
        else
        begin
            rgray_q <= b2g(new_instr & !is_rd(rx) ? '0 : (data_done &
                (cmd_q == `CSR_OP_RD_DATA) ? rptr_inc : rptr_q));
            wg_s1_q <= wgray_q;
            wg_s2_q <= wg_s1_q;
            da_s1_q <= da_q;
            da_s2_q <= da_s1_q;
            stl_s1_q <= stall_q;
            stl_s2_q <= stl_s1_q;
        end
    end

    // Output shifter, launches on falling edge, MSB first
    always_ff @(negedge spi_sck_i or negedge spi_rstn)
    begin
        if (!spi_rstn)
            tx_q <= 8'h00;
        else if (bit_q == 3'h0)
            tx_q <= nxt_q;
        else
            tx_q <= {tx_q[6:0], 1'h0};
    end

    assign serial_data_out_o = tx_q[7];
    assign serial_data_out_oe_o = ~spi_cs_n_i;

    // System domain decode
    wire evt = tg_s2_q ^ tg_s3_q;
    wire [FIFO_AW:0] rbin_sys = g2b(rg_s2_q);
    wire [FIFO_AW:0] level = wptr_q - rbin_sys;
    wire full = (level == FULL_LVL);
    wire run = (st_q == csr_pkg::CSR_RUN);
    wire dump = (st_q == csr_pkg::CSR_DUMP);
    wire pace = run & (cnt_q == 9'h000);
    wire push = ~full & (pace | dump);
    wire grp_end = (pix_q == `CSR_GROUP_LAST);
    wire x_end = grp_end & (xcnt_q == xsh_q);
    wire rep_end = x_end & (8'(rcnt_q + 8'h01) >= rep_q);
    wire scan_end = rep_end & (ycnt_q == ysh_q);
    wire [7:0] wdata = dump ? dump_byte(didx_q) : pix_data_i;
    wire [FIFO_AW:0] wptr_nxt = evt ? '0 : (push ? wptr_q + (FIFO_AW + 1)'(1'h1) : wptr_q);

    function automatic logic [7:0] dump_byte(input logic [3:0] i);
        case (i)
            4'h0: dump_byte = {6'h00, stall_q, uf_s2_q};
            4'h2: dump_byte = drive_q;
            4'h3: dump_byte = {6'h00, adc_q};
            4'h4: dump_byte = test_q;
            4'h5: dump_byte = thr_q;
            4'h7: dump_byte = xsh_q;
            4'h8: dump_byte = ysh_q;
            4'h9: dump_byte = rep_q;
            default: dump_byte = 8'h00;
        endcase
    endfunction : dump_byte

    // FIFO write port
    always_ff @(posedge clk_sys_i)
    begin
        if (push)
            mem[wptr_q[FIFO_AW-1:0]] <= wdata;
    end

    // System domain synchronisers and pointer
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tg_s1_q <= 1'h0;
            tg_s2_q <= 1'h0;
            tg_s3_q <= 1'h0;
            rg_s1_q <= '0;
            rg_s2_q <= '0;
            uf_s1_q <= 1'h0;
            uf_s2_q <= 1'h0;
            wptr_q <= '0;
            wgray_q <= '0;
            da_q <= 1'h0;
            strobe_q <= 1'h0;
        end
        else
        begin
            tg_s1_q <= tgl_q;
            tg_s2_q <= tg_s1_q;
            tg_s3_q <= tg_s2_q;
            rg_s1_q <= rgray_q;
            rg_s2_q <= rg_s1_q;
            uf_s1_q <= ufl_q;
            uf_s2_q <= uf_s1_q;
            wptr_q <= wptr_nxt;
            wgray_q <= b2g(wptr_nxt);
            da_q <= ({{(8 - FIFO_AW - 1){1'h0}}, level} >= thr_q);
            strobe_q <= push & run;
        end
    end

    // Control registers written by host commands
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            drive_q <= `CSR_RST_DRIVE;
            adc_q <= `CSR_RST_ADC;
            test_q <= `CSR_RST_TEST;
            thr_q <= `CSR_RST_THR;
            xpos_q <= `CSR_RST_POS;
            ypos_q <= `CSR_RST_POS;
            xsh_q <= `CSR_RST_XSHIFT;
            ysh_q <= `CSR_RST_YSHIFT;
            rep_q <= `CSR_RST_REPEAT;
        end
        else if (evt)
        begin
            case (cmd_q)
                `CSR_OP_WR_DRIVE: drive_q <= prm_q;
                `CSR_OP_WR_ADC: adc_q <= prm_q[1:0];
                `CSR_OP_WR_TEST: test_q <= prm_q;
                `CSR_OP_WR_THR: thr_q <= prm_q;
                `CSR_OP_WR_XPOS: xpos_q <= prm_q;
                `CSR_OP_WR_YPOS: ypos_q <= prm_q;
                `CSR_OP_WR_XSHIFT: xsh_q <= prm_q;
                `CSR_OP_WR_YSHIFT: ysh_q <= prm_q;
                `CSR_OP_WR_REPEAT: rep_q <= prm_q;
                default: ;
            endcase
        end
    end

    // Sense sequencer
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q <= csr_pkg::CSR_IDLE;
            cnt_q <= 9'h000;
            didx_q <= 4'h0;
            stall_q <= 1'h0;
        end
        else if (evt && (cmd_q == `CSR_OP_START))
        begin
            st_q <= csr_pkg::CSR_LAT;
            cnt_q <= LAT_LOAD;
            stall_q <= 1'h0;
        end
        else if (evt && (cmd_q == `CSR_OP_DUMP))
        begin
            st_q <= csr_pkg::CSR_DUMP;
            didx_q <= 4'h0;
            stall_q <= 1'h0;
        end
        else
        begin
            case (st_q)
                csr_pkg::CSR_LAT:
                begin
                    if (cnt_q == 9'h000)
                        st_q <= csr_pkg::CSR_RUN;
                    else
                        cnt_q <= cnt_q - 9'h001;
                end
                csr_pkg::CSR_RUN:
                begin
                    stall_q <= pace & full;
                    if (push)
                    begin
                        cnt_q <= PER_LOAD;
                        if (scan_end)
                            st_q <= csr_pkg::CSR_IDLE;
                    end
                    else if (!pace)
                        cnt_q <= cnt_q - 9'h001;
                end
                csr_pkg::CSR_DUMP:
                begin
                    if (push)
                    begin
                        didx_q <= didx_q + 4'h1;
                        if (didx_q == DUMP_LAST)
                            st_q <= csr_pkg::CSR_IDLE;
                    end
                end
                default: st_q <= csr_pkg::CSR_IDLE;
            endcase
        end
    end

    // Window address generator
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pix_q <= 3'h0;
            xcnt_q <= 8'h00;
            ycnt_q <= 8'h00;
            rcnt_q <= 8'h00;
            col_q <= 8'h00;
            row_q <= 8'h00;
        end
        else if (evt && (cmd_q == `CSR_OP_START))
        begin
            pix_q <= 3'h0;
            xcnt_q <= 8'h00;
            ycnt_q <= 8'h00;
            rcnt_q <= 8'h00;
            col_q <= xpos_q;
            row_q <= ypos_q;
        end
        else if (push && run)
        begin
            pix_q <= pix_q + 3'h1;
            col_q <= col_q + 8'h01;
            if (x_end)
            begin
                xcnt_q <= 8'h00;
                col_q <= xpos_q;
                if (rep_end)
                begin
                    rcnt_q <= 8'h00;
                    ycnt_q <= ycnt_q + 8'h01;
                    row_q <= row_q + 8'h01;
                end
                else
                    rcnt_q <= rcnt_q + 8'h01;
            end
            else if (grp_end)
                xcnt_q <= xcnt_q + 8'h01;
        end
    end

    assign pix_col_o = col_q;
    assign pix_row_o = row_q;
    assign pix_strobe_o = strobe_q;
    assign finger_drive_out_o = drive_q;
    assign adc_sens_o = adc_q;
    assign selftest_mode_o = test_q;
    assign sensing_o = (st_q != csr_pkg::CSR_IDLE);
    assign stall_o = stall_q;
    assign data_available_flag_o = da_q;
endmodule : csr_readout

`default_nettype wire

// ===== hdl/csr_map.svh
/*
 * Opcodes, reset values, positions and timing counts of the sensor readout.
 * Assumes inclusion by bare name from the readout design files.
 */
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

`define CSR_OP_START 8'h11
`define CSR_OP_RD_DATA 8'h20
`define CSR_OP_RD_STAT 8'h21
`define CSR_OP_DUMP 8'h50
`define CSR_OP_WR_DRIVE 8'h75
`define CSR_OP_WR_ADC 8'h76
`define CSR_OP_WR_TEST 8'h77
`define CSR_OP_WR_THR 8'h7C
`define CSR_OP_WR_XPOS 8'h7F
`define CSR_OP_WR_YPOS 8'h81
`define CSR_OP_WR_XSHIFT 8'h82
`define CSR_OP_WR_YSHIFT 8'h83
`define CSR_OP_WR_REPEAT 8'h84

`define CSR_RST_DRIVE 8'h00
`define CSR_RST_ADC 2'h3
`define CSR_RST_TEST 8'h00
`define CSR_RST_THR 8'h01
`define CSR_RST_POS 8'h00
`define CSR_RST_XSHIFT 8'h12
`define CSR_RST_YSHIFT 8'hC7
`define CSR_RST_REPEAT 8'h01

`define CSR_LAT_CYC 363
`define CSR_PIX_PERIOD 8
`define CSR_CLK_MHZ 25
`define CSR_MAX_MPIX 4
`define CSR_DUMP_LEN 16
`define CSR_GROUP_LAST 3'h7
`define CSR_BIT_LAST 3'h7

`define CSR_STAT_DA 0
`define CSR_STAT_STL 1
`define CSR_STAT_UFL 2
`define CSR_REG_UFL 0
`define CSR_REG_STL 1

`endif

// ===== hdl/csr_pkg.sv
/*
 * Types shared by the capacitive sensor readout.
 * Assumes nothing of its surroundings.
 */
package csr_pkg;
    typedef enum logic [1:0] {CSR_IDLE, CSR_LAT, CSR_RUN, CSR_DUMP} csr_state_e;
endpackage : csr_pkg

// ===== tb/csr_readout_asserts.sv
/*
 * Port checker for the capacitive sensor readout.
 * Assumes binding to csr_readout with the same latency parameter.
 */
`timescale 1ns/1ns
`default_nettype none

module csr_readout_asserts #(
    parameter int LAT_CYC = 363
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic spi_sck_i,
    input wire logic spi_cs_n_i,
    input wire logic serial_data_out_oe_o,
    input wire logic [7:0] pix_col_o,
    input wire logic [7:0] pix_row_o,
    input wire logic pix_strobe_o,
    input wire logic sensing_o,
    input wire logic stall_o
);
    logic sens_q;
    logic seen_q;
    logic [10:0] lat_q;

    // Cycles since the sequencer left idle, up to the first strobe
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sens_q <= 1'b0;
            seen_q <= 1'b0;
            lat_q <= 11'h000;
        end
        else
        begin
            sens_q <= sensing_o;
            if (sensing_o && !sens_q)
            begin
                lat_q <= 11'h001;
                seen_q <= 1'b0;
            end
            else
            begin
                lat_q <= (lat_q == 11'h7FF) ? lat_q : lat_q + 11'h001;
                seen_q <= seen_q | pix_strobe_o;
            end
        end
    end

    sequence s_quiet;
        !pix_strobe_o [*7];
    endsequence

    rate_limit_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        pix_strobe_o |=> s_quiet) else $error("pixel strobes closer than eight cycles");
    first_latency_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        pix_strobe_o && !seen_q |-> lat_q >= LAT_CYC - 2 && lat_q <= LAT_CYC + 4)
        else $error("first pixel outside latency window");
    stall_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        stall_o && $past(stall_o) && $past(stall_o, 2) |-> !pix_strobe_o)
        else $error("pixel pushed while stalled");
    stall_sensing_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        stall_o |-> sensing_o) else $error("stall without active scan");
    oe_follow_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        serial_data_out_oe_o == !spi_cs_n_i) else $error("output enable not tracking select");
    window_bound_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        pix_strobe_o |-> pix_col_o < 8'h98 && pix_row_o < 8'hC8)
        else $error("pixel address outside array");
    strobe_cause_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        pix_strobe_o |-> $past(sensing_o)) else $error("pixel strobe without scan");
    link_drive_a: assert property (@(posedge spi_sck_i) disable iff (spi_cs_n_i || !resetn_i)
        serial_data_out_oe_o) else $error("data output not driven in frame");
endmodule : csr_readout_asserts

bind csr_readout csr_readout_asserts #(.LAT_CYC(LAT_CYC)) chk_u (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .spi_sck_i(spi_sck_i),
    .spi_cs_n_i(spi_cs_n_i),
    .serial_data_out_oe_o(serial_data_out_oe_o),
    .pix_col_o(pix_col_o),
    .pix_row_o(pix_row_o),
    .pix_strobe_o(pix_strobe_o),
    .sensing_o(sensing_o),
    .stall_o(stall_o)
);

`default_nettype wire

// ===== tb/csr_spi_host.sv
/*
 * SPI master model of the host, mode 0, 80 ns clock within frames.
 * Assumes the bench calls its frame tasks in order.
 */
`timescale 1ns/1ns
`default_nettype none

module csr_spi_host (
    output logic spi_sck_o,
    output logic spi_cs_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    initial
    begin
        spi_sck_o = 1'b0;
        spi_cs_n_o = 1'b1;
        mosi_o = 1'b1;
    end

    task automatic open_frame;
        #13;
        spi_cs_n_o = 1'b0;
        #40;
    endtask : open_frame

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            mosi_o = tx[i];
            #40;
            spi_sck_o = 1'b1;
            rx[i] = miso_i;
            #40;
            spi_sck_o = 1'b0;
        end
    endtask : xfer

    task automatic close_frame;
        #40;
        spi_cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask : close_frame
endmodule : csr_spi_host

`default_nettype wire

// ===== tb/tb_top.sv
/*
 * Self-checking bench of the sensor readout: commands, dumps and a scan.
 * Assumes the design and checker files are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none
`include "csr_map.svh"

module tb_top;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    wire logic sck;
    wire logic cs_n;
    wire logic mosi;
    logic miso;
    logic oe;
    logic [7:0] col;
    logic [7:0] row;
    logic strobe;
    logic [7:0] drive;
    logic [1:0] adc;
    logic [7:0] test;
    logic sensing;
    logic stall;
    logic da;
    wire logic [7:0] pix;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [7:0] rx_q[$];
    logic [7:0] dump_exp [16] = '{8'h00, 8'h00, 8'hA5, 8'h01, 8'h3C, 8'h01, 8'h00, 8'h12,
        8'hC7, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    always #20 clk_sys_i = ~clk_sys_i;
    // Front end answers the column xored with the low row nibble in the upper four bits
    assign pix = col ^ {row[3:0], 4'h0};

    csr_readout #(.LAT_CYC(20)) dut_u (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
        .serial_data_in_i(mosi), .serial_data_out_o(miso), .serial_data_out_oe_o(oe),
        .pix_data_i(pix), .pix_col_o(col), .pix_row_o(row), .pix_strobe_o(strobe),
        .finger_drive_out_o(drive), .adc_sens_o(adc), .selftest_mode_o(test),
        .sensing_o(sensing), .stall_o(stall), .data_available_flag_o(da));

    csr_spi_host host_u (.spi_sck_o(sck), .spi_cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic give_up;
        n_mismatch++;
        print_verdict();
    endtask : give_up

    // Frame of opcode, parameter and n data bytes kept in rx_q
    task automatic frame(input logic [7:0] op, input logic [7:0] par, input int n);
        logic [7:0] rx;
        host_u.open_frame();
        host_u.xfer(op, rx);
        host_u.xfer(par, rx);
        repeat (n)
        begin
            host_u.xfer(8'h00, rx);
            rx_q.push_back(rx);
        end
        host_u.close_frame();
        repeat (10) @(negedge clk_sys_i);
    endtask : frame

    function automatic logic [7:0] pix_exp(input int k);
        logic [7:0] c;
        logic [7:0] r;
        c = 8'(8 + k % 8);
        r = 8'(3 + k / 16);
        return c ^ {r[3:0], 4'h0};
    endfunction : pix_exp

    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (3) @(negedge clk_sys_i);
        check({6'h00, adc}, 8'h03);
        check(drive, 8'h00);
        frame(`CSR_OP_WR_DRIVE, 8'hA5, 0);
        frame(`CSR_OP_WR_ADC, 8'h01, 0);
        frame(`CSR_OP_WR_TEST, 8'h3C, 0);
        check(drive, 8'hA5);
        check({6'h00, adc}, 8'h01);
        check(test, 8'h3C);
        // Dump read back over two frames split at a byte boundary
        frame(`CSR_OP_DUMP, 8'h00, 0);
        check({7'h00, da}, 8'h01);
        frame(`CSR_OP_RD_STAT, 8'h00, 1);
        check(rx_q.pop_front(), 8'h01);
        frame(`CSR_OP_RD_DATA, 8'h00, 10);
        frame(`CSR_OP_RD_DATA, 8'h00, 6);
        foreach (dump_exp[i]) check(rx_q.pop_front(), dump_exp[i]);
        // Threshold boundary, then pointer reset by a write
        frame(`CSR_OP_WR_THR, 8'h0E, 0);
        frame(`CSR_OP_DUMP, 8'h00, 0);
        // Fourteenth dump byte lands well after the frame's own wait
        repeat (16) @(negedge clk_sys_i);
        check({7'h00, da}, 8'h01);
        frame(`CSR_OP_RD_DATA, 8'h00, 3);
        for (int i = 0; i < 3; i++) check(rx_q.pop_front(), dump_exp[i]);
        check({7'h00, da}, 8'h00);
        frame(`CSR_OP_WR_THR, 8'h0D, 0);
        check({7'h00, da}, 8'h00);
        frame(`CSR_OP_RD_STAT, 8'h00, 1);
        check(rx_q.pop_front(), 8'h00);
        // Windowed scan larger than the FIFO
        frame(`CSR_OP_WR_THR, 8'h01, 0);
        frame(`CSR_OP_WR_XPOS, 8'h08, 0);
        frame(`CSR_OP_WR_YPOS, 8'h03, 0);
        frame(`CSR_OP_WR_XSHIFT, 8'h00, 0);
        frame(`CSR_OP_WR_YSHIFT, 8'h02, 0);
        frame(`CSR_OP_WR_REPEAT, 8'h02, 0);
        frame(`CSR_OP_START, 8'h00, 0);
        for (int i = 0; i < 3000 && stall !== 1'b1; i++) @(negedge clk_sys_i);
        if (stall !== 1'b1)
            give_up();
        check({7'h00, stall}, 8'h01);
        repeat (6) frame(`CSR_OP_RD_DATA, 8'h00, 8);
        for (int k = 0; k < 48; k++) check(rx_q.pop_front(), pix_exp(k));
        for (int i = 0; i < 400 && sensing !== 1'b0; i++) @(negedge clk_sys_i);
        check({7'h00, sensing}, 8'h00);
        check({7'h00, da}, 8'h00);
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
